//--- logic/rfoc_pkg.sv
package rfoc_pkg;
   // timing
   localparam int unsigned CLK_KHZ      = 125000;
   localparam int unsigned HOLD_MS      = 3000;
   localparam int unsigned BUSY_MS      = 3000;
   localparam int unsigned ABORT_MS     = 3000;
   localparam int unsigned HOLD_CYCLES  = HOLD_MS * CLK_KHZ;
   localparam int unsigned BUSY_CYCLES  = BUSY_MS * CLK_KHZ;
   localparam int unsigned ABORT_CYCLES = ABORT_MS * CLK_KHZ;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_WINDOW  = 8'h04;
   localparam logic [7:0] OFS_OFFSET  = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;
   localparam logic [7:0] OFS_DISPLAY = 8'h10;
   // control field positions
   localparam int CTRL_LEVEL_LSB = 0;
   localparam int CTRL_JCE_BIT   = 4;
   localparam int CTRL_FMT_LSB   = 8;
   localparam int CTRL_TYPE_LSB  = 12;
   localparam int OFFSET_NEG_BIT = 31;
   // reset values
   localparam logic [1:0]  LEVEL_RST = 2'h0;
   localparam logic        JCE_RST   = 1'b1;
   localparam logic [1:0]  FMT_RST   = 2'h0;
   localparam logic [3:0]  TYPE_RST  = 4'h2;
   localparam logic [19:0] WIN_RST   = 20'h00000;
   localparam logic [19:0] OFS_RST   = 20'h00000;
   localparam logic [19:0] WIN_MAX   = 20'h00099;
   // input types, last one is the millivolt mode
   localparam logic [3:0] TYPE_R  = 4'h4;
   localparam logic [3:0] TYPE_S  = 4'h5;
   localparam logic [3:0] TYPE_B  = 4'h6;
   localparam logic [3:0] TYPE_MV = 4'h8;
   // calibration sequence: 8 voltage points then 6 resistance points
   localparam logic [3:0] CAL_LAST = 4'hD;
   // access codes, values arbitrary
   localparam logic [19:0] CAL_CODE_DEF  = 20'h00001;
   localparam logic [19:0] DIAG_CODE_DEF = 20'h00005;
   localparam logic [2:0] DIG_SIGN = 3'h5;
   localparam logic [2:0] DIG_NONE = 3'h6;

   typedef enum logic [6:0] {
      IT_TYPE = 7'h01, IT_JCE = 7'h02, IT_FMT = 7'h04, IT_FILT = 7'h08,
      IT_WIN = 7'h10, IT_OFS = 7'h20, IT_CAL = 7'h40
   } rfoc_item_e;

   typedef enum logic [5:0] {
      PH_MENU = 6'h01, PH_CODE = 6'h02, PH_ABORT = 6'h04, PH_CALPT = 6'h08,
      PH_BUSY = 6'h10, PH_SPARE = 6'h20
   } rfoc_phase_e;
endpackage

//--- logic/rfoc_top.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
// Functional notes
// - levels 0..3; level 0 passes sample through
// - level 1: quarter new, three quarters old
// - level 2: eighth new, seven eighths old
// - level 3: sixteenth new, fifteen sixteenths old
// - filter only inside +-window, window 0..99
// - outside window sample displayed directly
// - signed offset +-99999 added to display
// - scroll toggles junction compensation enable
// - compensation item skipped in millivolt mode
// - four formats, scroll cycles and applies at once, advance moves on
// - no tenths for types R, S, B
// - window digits edited, 3 s hold commits
// - offset digits and sign, wrap to LSD
// - zero code hold aborts, back to type
// - eight voltage points, busy after each
// - six resistance points, then calibration item
// - diagnostic code sets non-retained resistance mode
module rfoc_top
   import rfoc_pkg::*;
#(
   parameter int unsigned  HOLD_CYC  = HOLD_CYCLES,
   parameter int unsigned  BUSY_CYC  = BUSY_CYCLES,
   parameter int unsigned  ABORT_CYC = ABORT_CYCLES,
   parameter logic [19:0]  CAL_CODE  = CAL_CODE_DEF,
   parameter logic [19:0]  DIAG_CODE = DIAG_CODE_DEF
)(
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        SYS_RST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // readings and buttons
   input  wire logic        SAMPLE_VALID,
   input  wire logic [23:0] SAMPLE_DATA,
   input  wire logic        BTN_SCROLL,
   input  wire logic        BTN_ADVANCE,
   // display and calibration
   output logic      [23:0] DISPLAY_VALUE,
   output logic             DISPLAY_VALID,
   output logic      [1:0]  DISPLAY_FORMAT,
   output logic             JUNCTION_COMP_ON,
   output logic             CAL_CAPTURE,
   output logic      [3:0]  CAL_POINT,
   output logic             CAL_BUSY,
   output logic             RESIST_DISPLAY
);

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        s1_scr, s2_scr, scr_q;
      logic        s1_adv, s2_adv, adv_q;
      logic [31:0] hold_cnt;
      logic [31:0] tmr;
      logic [1:0]  filter_level;
      logic        junction_comp_enable;
      logic [1:0]  display_format;
      logic [3:0]  input_type;
      logic [19:0] filter_window;
      logic        ofs_neg;
      logic [19:0] display_offset;
      rfoc_item_e  item;
      rfoc_phase_e phase;
      logic [19:0] edit;
      logic        edit_neg;
      logic [2:0]  digit;
      logic        cal_yes;
      logic [3:0]  cal_step;
      logic        diag;
      logic        have_prev;
      logic [23:0] filt;
      logic [23:0] disp;
      logic        disp_valid;
      logic        cal_capture;
      logic        cal_busy;
      logic        jcomp;
   } rfoc_state_s;

   rfoc_state_s r, n;
   logic        scr_p, adv_p, hold_evt, rsb, in_win, millivolt_mode;
   logic [16:0] win_bin, ofs_bin;
   logic [24:0] diff, absdiff, shifted, ofs_s;
   logic [23:0] newv;
   logic [2:0]  shamt;

   function automatic logic [16:0] bcd2bin(input logic [19:0] b);
      logic [16:0] v;
      v = '0;
      for (int i = 4; i >= 0; i--)
         v = 17'(v * 17'd10 + 17'(b[i*4 +: 4]));
      return v;
   endfunction

   function automatic logic [19:0] inc_digit(input logic [19:0] b, input logic [2:0] d);
      logic [19:0] o;
      o = b;
      o[int'(d)*4 +: 4] = (b[int'(d)*4 +: 4] >= 4'h9) ? 4'h0 : 4'(b[int'(d)*4 +: 4] + 4'h1);
      return o;
   endfunction

   function automatic rfoc_item_e next_item(input rfoc_item_e it, input logic mv);
      case (it)
         IT_TYPE: next_item = mv ? IT_FILT : IT_JCE;
         IT_JCE:  next_item = IT_FMT;
         IT_FMT:  next_item = IT_FILT;
         IT_FILT: next_item = IT_WIN;
         IT_WIN:  next_item = IT_OFS;
         IT_OFS:  next_item = IT_CAL;
         default: next_item = IT_TYPE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // filter datapath
   always_comb
   begin
      millivolt_mode = (r.input_type == TYPE_MV);
      rsb     = (r.input_type == TYPE_R) || (r.input_type == TYPE_S) || (r.input_type == TYPE_B);
      win_bin = bcd2bin(r.filter_window);
      ofs_bin = bcd2bin(r.display_offset);
      ofs_s   = r.ofs_neg ? 25'(-{8'h00, ofs_bin}) : {8'h00, ofs_bin};
      diff    = 25'({SAMPLE_DATA[23], SAMPLE_DATA} - {r.filt[23], r.filt});
      absdiff = diff[24] ? 25'(-diff) : diff;
      in_win  = r.have_prev && (absdiff <= {8'h00, win_bin});
      shamt   = 3'(r.filter_level) + 3'h1;
      shifted = 25'($signed(diff) >>> shamt);
      if (r.filter_level == 2'h0 || !in_win)
         newv = SAMPLE_DATA;
      else
         newv = 24'(r.filt + shifted[23:0]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      n = r;
      n.s1_scr = BTN_SCROLL;
      n.s2_scr = r.s1_scr;
      n.scr_q  = r.s2_scr;
      n.s1_adv = BTN_ADVANCE;
      n.s2_adv = r.s1_adv;
      n.adv_q  = r.s2_adv;
      scr_p    = r.s2_scr && !r.scr_q;
      adv_p    = r.s2_adv && !r.adv_q;
      hold_evt = r.s2_adv && (r.hold_cnt == HOLD_CYC - 1);
      if (!r.s2_adv)
         n.hold_cnt = '0;
      else if (r.hold_cnt != HOLD_CYC)
         n.hold_cnt = r.hold_cnt + 32'h1;
      n.cal_capture = 1'b0;
      n.disp_valid  = 1'b0;

      if (SAMPLE_VALID)
      begin
         n.filt       = newv;
         n.have_prev  = 1'b1;
         n.disp       = 24'(newv + ofs_s[23:0]);
         n.disp_valid = 1'b1;
      end

      case (r.phase)
         PH_MENU:
         begin
            case (r.item)
               IT_TYPE:
               begin
                  if (scr_p)
                     n.input_type = (r.input_type >= TYPE_MV) ? 4'h0 : 4'(r.input_type + 4'h1);
               end
               IT_JCE:
               begin
                  if (scr_p)
                     n.junction_comp_enable = !r.junction_comp_enable;
               end
               IT_FMT:
               begin
                  if (scr_p)
                     n.display_format = rsb ? {!r.display_format[1], 1'b0}
                                            : 2'(r.display_format + 2'h1);
               end
               IT_FILT:
               begin
                  if (scr_p)
                     n.filter_level = 2'(r.filter_level + 2'h1);
               end
               IT_WIN:
               begin
                  if (scr_p)
                     n.edit = inc_digit(r.edit, r.digit);
                  if (adv_p)
                     n.digit = (r.digit == 3'h4) ? 3'h0 : 3'(r.digit + 3'h1);
                  if (hold_evt)
                  begin
                     n.filter_window = (bcd2bin(r.edit) > 17'd99) ? WIN_MAX : r.edit;
                     n.item     = IT_OFS;
                     n.edit     = r.display_offset;
                     n.edit_neg = r.ofs_neg;
                     n.digit    = 3'h0;
                  end
               end
               IT_OFS:
               begin
                  if (scr_p)
                  begin
                     if (r.digit < DIG_SIGN)
                        n.edit = inc_digit(r.edit, r.digit);
                     else
                        n.edit_neg = !r.edit_neg;
                  end
                  if (adv_p)
                     n.digit = (r.digit == DIG_NONE) ? 3'h0 : 3'(r.digit + 3'h1);
                  if (hold_evt)
                  begin
                     n.display_offset = r.edit;
                     n.ofs_neg = r.edit_neg;
                     n.item    = IT_CAL;
                     n.cal_yes = 1'b0;
                  end
               end
               default:
               begin
                  if (scr_p)
                     n.cal_yes = !r.cal_yes;
               end
            endcase
            if (adv_p && r.item != IT_WIN && r.item != IT_OFS)
            begin
               n.item = next_item(r.item, millivolt_mode);
               if (r.item == IT_FILT)
               begin
                  n.edit  = r.filter_window;
                  n.digit = 3'h0;
               end
               if (r.item == IT_CAL && r.cal_yes)
               begin
                  n.item  = IT_CAL;
                  n.phase = PH_CODE;
                  n.edit  = '0;
                  n.digit = 3'h0;
               end
            end
         end
         PH_CODE:
         begin
            if (scr_p)
               n.edit = inc_digit(r.edit, r.digit);
            if (adv_p)
               n.digit = (r.digit == 3'h4) ? 3'h0 : 3'(r.digit + 3'h1);
            if (hold_evt)
            begin
               n.tmr = '0;
               if (r.edit == 20'h00000)
                  n.phase = PH_ABORT;
               else if (r.edit == CAL_CODE)
               begin
                  n.phase    = PH_CALPT;
                  n.cal_step = 4'h0;
               end
               else
               begin
                  n.diag  = (r.edit == DIAG_CODE) ? 1'b1 : r.diag;
                  n.phase = PH_MENU;
                  n.item  = IT_CAL;
               end
            end
         end
         PH_ABORT:
         begin
            n.tmr = r.tmr + 32'h1;
            if (r.tmr >= ABORT_CYC - 1)
            begin
               n.phase = PH_MENU;
               n.item  = IT_TYPE;
            end
         end
         PH_CALPT:
         begin
            if (adv_p)
            begin
               n.cal_capture = 1'b1;
               n.phase       = PH_BUSY;
               n.tmr         = '0;
            end
         end
         PH_BUSY:
         begin
            n.tmr = r.tmr + 32'h1;
            if (r.tmr >= BUSY_CYC - 1)
            begin
               if (r.cal_step == CAL_LAST)
               begin
                  n.phase   = PH_MENU;
                  n.item    = IT_CAL;
                  n.cal_yes = 1'b0;
               end
               else
               begin
                  n.phase    = PH_CALPT;
                  n.cal_step = 4'(r.cal_step + 4'h1);
               end
            end
         end
         default:
            n.phase = PH_MENU;
      endcase

      // apb: setup cycle answers, access edge writes
      n.pready  = PSEL && !PENABLE;
      n.pslverr = 1'b0;
      n.prdata  = '0;
      if (PSEL && !PENABLE)
      begin
         case (PADDR)
            OFS_CTRL:    n.prdata = {16'h0000, r.input_type, 2'h0, r.display_format, 3'h0,
                                     r.junction_comp_enable, 2'h0, r.filter_level};
            OFS_WINDOW:  n.prdata = {12'h000, r.filter_window};
            OFS_OFFSET:  n.prdata = {r.ofs_neg, 11'h000, r.display_offset};
            OFS_STATUS:  n.prdata = {5'h00, r.digit, 2'h0, r.cal_yes, r.diag, r.cal_step,
                                     2'h0, r.phase, 1'b0, r.item};
            OFS_DISPLAY: n.prdata = {{8{r.disp[23]}}, r.disp};
            default:     n.pslverr = 1'b1;
         endcase
      end
      if (PSEL && PENABLE && r.pready && PWRITE)
      begin
         case (PADDR)
            OFS_CTRL:
            begin
               n.filter_level         = PWDATA[CTRL_LEVEL_LSB +: 2];
               n.junction_comp_enable = PWDATA[CTRL_JCE_BIT];
               n.display_format       = PWDATA[CTRL_FMT_LSB +: 2];
               if (PWDATA[CTRL_TYPE_LSB +: 4] <= TYPE_MV)
                  n.input_type = PWDATA[CTRL_TYPE_LSB +: 4];
            end
            OFS_WINDOW:
               n.filter_window = (bcd2bin(PWDATA[19:0]) > 17'd99) ? WIN_MAX : PWDATA[19:0];
            OFS_OFFSET:
            begin
               n.display_offset = PWDATA[19:0];
               n.ofs_neg        = PWDATA[OFFSET_NEG_BIT];
            end
            default:
               n.pslverr = r.pslverr;
         endcase
      end

      if (n.input_type == TYPE_R || n.input_type == TYPE_S || n.input_type == TYPE_B)
         n.display_format[0] = 1'b0;
      n.jcomp    = n.junction_comp_enable && (n.input_type != TYPE_MV);
      n.cal_busy = (n.phase == PH_BUSY);
   end

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         r                      <= '0;
         r.filter_level         <= LEVEL_RST;
         r.junction_comp_enable <= JCE_RST;
         r.display_format       <= FMT_RST;
         r.input_type           <= TYPE_RST;
         r.filter_window        <= WIN_RST;
         r.display_offset       <= OFS_RST;
         r.item                 <= IT_TYPE;
         r.phase                <= PH_MENU;
         r.jcomp                <= JCE_RST;
      end
      else
         r <= n;
   end

   assign PRDATA           = r.prdata;
   assign PREADY           = r.pready;
   assign PSLVERR          = r.pslverr;
   assign DISPLAY_VALUE    = r.disp;
   assign DISPLAY_VALID    = r.disp_valid;
   assign DISPLAY_FORMAT   = r.display_format;
   assign JUNCTION_COMP_ON = r.jcomp;
   assign CAL_CAPTURE      = r.cal_capture;
   assign CAL_POINT        = r.cal_step;
   assign CAL_BUSY         = r.cal_busy;
   assign RESIST_DISPLAY   = r.diag;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   property p_pass;
      SAMPLE_VALID && r.filter_level == 2'h0 |=> r.filt == $past(SAMPLE_DATA);
   endproperty
   a_pass: assert property (p_pass) else $error("level zero did not pass sample");
   property p_lvl1;
      SAMPLE_VALID && r.filter_level == 2'h1 && in_win
         |=> r.filt == 24'($past(r.filt) + 24'($signed($past(diff)) >>> 2));
   endproperty
   a_lvl1: assert property (p_lvl1) else $error("level one weighting wrong");
   property p_lvl2;
      SAMPLE_VALID && r.filter_level == 2'h2 && in_win
         |=> r.filt == 24'($past(r.filt) + 24'($signed($past(diff)) >>> 3));
   endproperty
   a_lvl2: assert property (p_lvl2) else $error("level two weighting wrong");
   property p_lvl3;
      SAMPLE_VALID && r.filter_level == 2'h3 && in_win
         |=> r.filt == 24'($past(r.filt) + 24'($signed($past(diff)) >>> 4));
   endproperty
   a_lvl3: assert property (p_lvl3) else $error("level three weighting wrong");
   property p_outside;
      SAMPLE_VALID && !in_win |=> r.filt == $past(SAMPLE_DATA) ##0 DISPLAY_VALID;
   endproperty
   a_outside: assert property (p_outside) else $error("out of window sample was filtered");
   property p_offset;
      DISPLAY_VALID && $stable(ofs_s) |-> DISPLAY_VALUE == 24'(r.filt + ofs_s[23:0]);
   endproperty
   a_offset: assert property (p_offset) else $error("offset not applied to display");
   property p_no_tenths;
      rsb |-> !DISPLAY_FORMAT[0];
   endproperty
   a_no_tenths: assert property (p_no_tenths) else $error("tenths selected for R S B");
   property p_abort;
      r.phase == PH_ABORT && r.tmr >= ABORT_CYC - 1 |=> r.phase == PH_MENU && r.item == IT_TYPE;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not return to type item");
   property p_cal_end;
      r.phase == PH_BUSY && r.cal_step == CAL_LAST && r.tmr >= BUSY_CYC - 1 |=> r.item == IT_CAL && !CAL_BUSY;
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration did not end at cal item");
   property p_busy;
      CAL_CAPTURE |-> CAL_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("no busy after calibration point");

   c_filtered: cover property (SAMPLE_VALID && in_win && r.filter_level == 2'h3);
   c_cal_done: cover property (CAL_CAPTURE && CAL_POINT == CAL_LAST);
   c_abort:    cover property (r.phase == PH_ABORT ##1 r.phase == PH_MENU);
   c_diag:     cover property ($rose(RESIST_DISPLAY));
endmodule

//--- dv/rfoc_panel_model.sv
`timescale 1ns/100ps
module rfoc_panel_model (
   // clock
   input  wire logic        clk,
   // readings and buttons
   output logic             sample_valid,
   output logic      [23:0] sample_data,
   output logic             btn_scroll,
   output logic             btn_advance
);
   initial
   begin
      sample_valid = 1'b0;
      sample_data  = 24'h000000;
      btn_scroll   = 1'b0;
      btn_advance  = 1'b0;
   end

   // one reading; data line scrambled once the strobe drops
   task automatic send(input logic [23:0] d);
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_data  <= d;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample_data  <= ~d;
   endtask

   // press for len cycles, then released and quiet for a while
   task automatic push(input logic adv, input int len);
      @(posedge clk);
      if (adv)
         btn_advance <= 1'b1;
      else
         btn_scroll <= 1'b1;
      repeat (len) @(posedge clk);
      btn_advance <= 1'b0;
      btn_scroll  <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import rfoc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        s_valid;
   logic [23:0] s_data;
   logic        b_scroll;
   logic        b_adv;
   logic [23:0] disp;
   logic        disp_valid;
   logic        jc_on;
   logic        capture;
   logic [3:0]  point;
   logic        busy;
   logic [1:0]  fmt;
   logic        resist;
   logic [31:0] rd;
   logic        er;
   int          errors = 0;
   int          n_checks = 0;

   initial
   begin
      forever #4 clk = ~clk;
   end

   rfoc_top #(.HOLD_CYC(20), .BUSY_CYC(20), .ABORT_CYC(20)) rfoc_top_inst (
      .CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SAMPLE_VALID(s_valid), .SAMPLE_DATA(s_data), .BTN_SCROLL(b_scroll), .BTN_ADVANCE(b_adv),
      .DISPLAY_VALUE(disp), .DISPLAY_VALID(disp_valid), .DISPLAY_FORMAT(fmt), .JUNCTION_COMP_ON(jc_on),
      .CAL_CAPTURE(capture), .CAL_POINT(point), .CAL_BUSY(busy), .RESIST_DISPLAY(resist));

   rfoc_panel_model rfoc_panel_model_inst (
      .clk(clk), .sample_valid(s_valid), .sample_data(s_data), .btn_scroll(b_scroll),
      .btn_advance(b_adv));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic sample(input logic [23:0] d, input logic [23:0] exp);
      rfoc_panel_model_inst.send(d);
      #1;
      check(disp_valid, 1);
      check(disp, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_filter;
      for (int l = 1; l <= 3; l++)
      begin
         apb(1, OFS_CTRL, 32'h00002010);
         sample(24'd1000, 24'd1000);
         apb(1, OFS_CTRL, 32'h00002010 | l);
         sample(24'd1064, 24'd1000 + (24'd64 >> (l + 1)));
      end
      sample(24'd1104, 24'd1104);
      sample(24'd1005, 24'd1097);
   endtask

   task automatic t_offset;
      apb(1, OFS_CTRL, 32'h00002010);
      apb(1, OFS_OFFSET, 32'h80000475);
      sample(24'd2000, 24'd1525);
      apb(1, OFS_OFFSET, 32'h00000000);
   endtask

   task automatic t_junction;
      rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      check(jc_on, 0);
      apb(0, OFS_CTRL, 0);
      check(rd[4], 0);
      rfoc_panel_model_inst.push(0, 4);
      check(jc_on, 1);
      apb(1, OFS_CTRL, 32'h00008010);
      #20;
      check(jc_on, 0);
      apb(1, OFS_CTRL, 32'h00002010);
      rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      check(fmt, 1);
      apb(1, OFS_CTRL, 32'h00004110);
      @(negedge clk);
      check(fmt, 0);
      apb(1, OFS_CTRL, 32'h00002010);
   endtask

   task automatic t_calibrate;
      int n;
      for (int i = 0; i < 2; i++)
         rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 40);
      apb(0, OFS_WINDOW, 0);
      check(rd, 32'h00000090);
      for (int i = 0; i < 6; i++)
         rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 40);
      apb(0, OFS_OFFSET, 0);
      check(rd, 32'h80000001);
      apb(0, OFS_STATUS, 0);
      check(rd[6:0], IT_CAL);
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 40);
      for (int i = 0; i < 14; i++)
      begin
         n = 0;
         fork
            rfoc_panel_model_inst.push(1, 4);
            while (capture !== 1'b1 && n < 40)
            begin
               @(negedge clk);
               n++;
            end
         join_any
         check(capture, 1);
         check(point, i);
         repeat (2) @(negedge clk);
         check(busy, 1);
         wait fork;
         n = 0;
         while (busy !== 1'b0 && n < 100)
         begin
            @(negedge clk);
            n++;
         end
         check(busy, 0);
      end
      apb(0, OFS_STATUS, 0);
      check(rd[6:0], IT_CAL);
   endtask

   task automatic t_diag_abort;
      rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 4);
      for (int i = 0; i < 5; i++)
         rfoc_panel_model_inst.push(0, 4);
      rfoc_panel_model_inst.push(1, 40);
      check(resist, 1);
      rfoc_panel_model_inst.push(1, 4);
      rfoc_panel_model_inst.push(1, 40);
      repeat (4) @(posedge clk);
      apb(0, OFS_STATUS, 0);
      check(rd[13:0], {PH_MENU, 1'b0, IT_TYPE});
      apb(1, OFS_CTRL, 32'h00008010);
      rfoc_panel_model_inst.push(1, 4);
      apb(0, OFS_STATUS, 0);
      check(rd[6:0], IT_FILT);
      apb(1, OFS_CTRL, 32'h00002010);
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(jc_on, 1);
      check(resist, 0);
      apb(0, OFS_CTRL, 0);
      check(rd, 32'h00002010);
      apb(0, 8'h14, 0);
      check(er, 1);
      check(rd, 32'h00000000);
      apb(1, OFS_WINDOW, 32'h00000099);
      t_filter();
      t_offset();
      t_junction();
      t_calibrate();
      t_diag_abort();
      finish_test();
   end

   initial
   begin
      #160000;
      errors++;
      finish_test();
   end
endmodule
